// *** hdl/adsd_defs.svh ***
`ifndef ADSD_DEFS_SVH
`define ADSD_DEFS_SVH

// ********************************
// register indexes (byte address = index * 4)
// ********************************
`define ADSD_CTRL_IDX 12'hfbe
`define ADSD_STAT_IDX 12'hfbf

// ********************************
// reset values
// ********************************
`define ADSD_CTRL_RST 8'h00
`define ADSD_STAT_RST 8'h00

// ********************************
// field positions
// ********************************
`define ADSD_EN_BIT 7
`define ADSD_SCAN_IRQ_ENABLE_BIT 6
`define ADSD_LAST_MSB 3
`define ADSD_LAST_LSB 0
`define ADSD_CUR_MSB 7
`define ADSD_CUR_LSB 4
`define ADSD_FLAG_SCAN 2
`define ADSD_FLAG_CH1 1
`define ADSD_FLAG_CH0 0

// ********************************
// limits and bus answers
// ********************************
`define ADSD_LAST_MAX 4'hb
`define ADSD_RESP_OKAY 2'b00
`define ADSD_RESP_SLVERR 2'b10

`endif

// *** hdl/adsd_pkg.sv ***
package adsd_pkg;
	// sequencer states, gray coded along idle -> request -> wait -> transfer; transfer -> request flips both bits
	typedef enum logic [1:0] {
		adsd_idle = 2'b00,
		adsd_conv_req = 2'b01,
		adsd_conv_wait = 2'b11,
		adsd_xfer = 2'b10
	} adsd_state_e;
endpackage

// *** hdl/adsd_result_writer.sv ***
`timescale 1ns/100ps
`include "adsd_defs.svh"

module adsd_result_writer (
	input wire logic aclk, // system clock
	input wire logic aresetn, // synchronous reset, active low
	input wire logic start, // one-cycle request to store a result
	input wire logic abort, // drop any write under way
	input wire logic [6:0] base_upper, // upper seven address bits
	input wire logic [3:0] input_number, // analog input of the result
	input wire logic [9:0] result, // ten-bit conversion value
	output logic rf_wr_valid, // byte write offered
	input wire logic rf_wr_ready, // register file takes the byte
	output logic [11:0] rf_wr_addr, // byte address
	output logic [7:0] rf_wr_data, // byte data
	output logic done // one-cycle pulse after the odd byte
);
	logic second;
	logic [1:0] low_bits;
	wire take = rf_wr_valid && rf_wr_ready;

	// ********************************
	// two byte writes: high part even, low part odd
	// ********************************
	always_ff @(posedge aclk) begin
		if (!aresetn || abort) begin
			rf_wr_valid <= 1'b0;
			rf_wr_addr <= 12'h000;
			rf_wr_data <= 8'h00;
			second <= 1'b0;
			low_bits <= 2'b00;
			done <= 1'b0;
		end else begin
			done <= 1'b0;
			if (start && !rf_wr_valid) begin
				rf_wr_valid <= 1'b1;
				rf_wr_addr <= {base_upper, input_number, 1'b0};
				rf_wr_data <= result[9:2];
				low_bits <= result[1:0];
				second <= 1'b0;
			end else if (take && !second) begin
				rf_wr_addr <= {rf_wr_addr[11:1], 1'b1};
				rf_wr_data <= {low_bits, 6'h00};
				second <= 1'b1;
			end else if (take) begin
				rf_wr_valid <= 1'b0;
				second <= 1'b0;
				done <= 1'b1;
			end
		end
	end
endmodule

// *** hdl/adsd_scan_dma.sv ***
`timescale 1ns/100ps
`include "adsd_defs.svh"

// Summary of operation
// - enable clear stops the channel and forces last-input field to zero
// - with interrupt enable set, interrupt after storing the last input's result
// - with interrupt enable clear, the channel never raises an interrupt
// - last-input value N from 0 to 11 updates inputs 0 through N
// - each input is converted first, then its result is transferred
// - status upper nibble shows the input now being converted
// - any status read clears all three indicator bits
// - scan indicator set when last input stored and interrupt raised
// - channel one indicator set when that channel finishes and interrupts
// - channel zero indicator set when that channel finishes and interrupts
// - automatic conversion and transfer for one up to twelve inputs
// - every result handled is a ten-bit value
// - address is upper seven bits, input number, then a zero
// - high byte at even address, remaining bits at the odd address
module adsd_scan_dma #(
	parameter int ADDR_W = 16 // axi address width
) (
	input wire logic aclk, // system clock, 200 MHz
	input wire logic aresetn, // synchronous reset, active low
	input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
	input wire logic [2:0] s_axi_awprot, // write protection, unused
	input wire logic s_axi_awvalid, // write address valid
	output logic s_axi_awready, // write address ready
	input wire logic [31:0] s_axi_wdata, // write data
	input wire logic [3:0] s_axi_wstrb, // write strobes
	input wire logic s_axi_wvalid, // write data valid
	output logic s_axi_wready, // write data ready
	output logic [1:0] s_axi_bresp, // write response
	output logic s_axi_bvalid, // write response valid
	input wire logic s_axi_bready, // write response ready
	input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
	input wire logic [2:0] s_axi_arprot, // read protection, unused
	input wire logic s_axi_arvalid, // read address valid
	output logic s_axi_arready, // read address ready
	output logic [31:0] s_axi_rdata, // read data
	output logic [1:0] s_axi_rresp, // read response
	output logic s_axi_rvalid, // read data valid
	input wire logic s_axi_rready, // read data ready
	input wire logic [6:0] result_base_upper_bits, // upper address bits of result block
	output logic conv_start, // one-cycle conversion request
	output logic [3:0] conv_input, // analog input to convert
	input wire logic conv_done, // one-cycle end of conversion
	input wire logic [9:0] conv_result, // result, valid with conv_done
	output logic rf_wr_valid, // register file byte write offered
	input wire logic rf_wr_ready, // register file takes the byte
	output logic [11:0] rf_wr_addr, // register file byte address
	output logic [7:0] rf_wr_data, // register file byte data
	input wire logic chan0_done, // general channel zero end pulse
	input wire logic chan1_done, // general channel one end pulse
	output logic scan_irq // one-cycle interrupt after a full scan
);
	// the index decode needs twelve address bits above the byte lane
	generate
		if (ADDR_W < 14) begin : g_addr_check
			$error("ADDR_W must be at least 14");
		end
	endgenerate

	// reset images of both registers, taken apart field by field below
	localparam logic [7:0] CTRL_RST = `ADSD_CTRL_RST;
	localparam logic [7:0] STAT_RST = `ADSD_STAT_RST;

	// ********************************
	// address decode
	// ********************************
	// true when a byte address falls on the given register index
	function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [11:0] idx);
		hits = (addr[ADDR_W-1:2] == (ADDR_W-2)'(idx));
	endfunction

	// ********************************
	// state
	// ********************************
	// register fields
	logic ctrl_en;
	logic ctrl_scan_irq_enable;
	logic [3:0] ctrl_last;
	logic flag_scan;
	logic flag_ch1;
	logic flag_ch0;
	logic [3:0] cur;
	adsd_pkg::adsd_state_e state;
	adsd_pkg::adsd_state_e next_state;
	// write channel holding registers
	logic aw_held;
	logic w_held;
	logic [ADDR_W-1:0] aw_addr_q;
	logic [7:0] wdata_q;
	logic wstrb_q;
	// hand-off from sequencer to result writer
	logic wr_start;
	logic [9:0] result_q;
	logic wr_done;

	// ********************************
	// write channel
	// ********************************
	// each channel may arrive alone; both are held until the write happens
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready = !w_held && !s_axi_bvalid;
	wire do_write = aw_held && w_held && !s_axi_bvalid;
	wire wr_ctrl = hits(aw_addr_q, `ADSD_CTRL_IDX);
	wire wr_stat = hits(aw_addr_q, `ADSD_STAT_IDX);
	wire ctrl_write = do_write && wr_ctrl && wstrb_q;

	// address and data parked until both are in, then the write lands with its response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr_q <= '0;
			wdata_q <= 8'h00;
			wstrb_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ADSD_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held <= 1'b1;
				wdata_q <= s_axi_wdata[7:0];
				wstrb_q <= s_axi_wstrb[0];
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (wr_ctrl || wr_stat) ? `ADSD_RESP_OKAY : `ADSD_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ********************************
	// control register
	// ********************************
	// bits five and four are not stored; software keeps them zero anyway
	wire next_en = ctrl_write ? wdata_q[`ADSD_EN_BIT] : ctrl_en;
	// field clear follows the enable of this cycle, so a disabling write drops its own field
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_en <= CTRL_RST[`ADSD_EN_BIT];
			ctrl_scan_irq_enable <= CTRL_RST[`ADSD_SCAN_IRQ_ENABLE_BIT];
			ctrl_last <= CTRL_RST[`ADSD_LAST_MSB:`ADSD_LAST_LSB];
		end else begin
			ctrl_en <= next_en;
			if (ctrl_write) begin
				ctrl_scan_irq_enable <= wdata_q[`ADSD_SCAN_IRQ_ENABLE_BIT];
			end
			if (!next_en) begin
				ctrl_last <= 4'h0;
			end else if (ctrl_write) begin
				ctrl_last <= wdata_q[`ADSD_LAST_MSB:`ADSD_LAST_LSB];
			end
		end
	end

	// reserved codes are clamped so the scan can never run past input eleven
	wire [3:0] eff_last = (ctrl_last > `ADSD_LAST_MAX) ? `ADSD_LAST_MAX : ctrl_last;
	wire at_last = (cur >= eff_last);

	// ********************************
	// read channel
	// ********************************
	// address refused while read data waits, so one read at a time
	assign s_axi_arready = !s_axi_rvalid;
	wire rd_take = s_axi_arvalid && s_axi_arready;
	wire rd_ctrl = hits(s_axi_araddr, `ADSD_CTRL_IDX);
	wire rd_stat = hits(s_axi_araddr, `ADSD_STAT_IDX);
	// reserved control bits read back as zero
	wire [7:0] ctrl_view = {ctrl_en, ctrl_scan_irq_enable, 2'b00, ctrl_last};
	wire [7:0] stat_view = {cur, 1'b0, flag_scan, flag_ch1, flag_ch0};
	wire [7:0] rd_byte = rd_ctrl ? ctrl_view : (rd_stat ? stat_view : 8'h00);

	// data captured at the handshake; a status read returns the flags before they clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `ADSD_RESP_OKAY;
		end else if (rd_take) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {24'h00_0000, rd_byte};
			s_axi_rresp <= (rd_ctrl || rd_stat) ? `ADSD_RESP_OKAY : `ADSD_RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ********************************
	// scan sequencer
	// ********************************
	// a scan ends when the last input's odd byte is stored
	wire scan_end = (state == adsd_pkg::adsd_xfer) && wr_done && at_last;
	wire raise_irq = scan_end && ctrl_scan_irq_enable;

	// next state; disable always wins and parks the channel
	always_comb begin
		next_state = state;
		case (state)
			adsd_pkg::adsd_idle: begin
				if (ctrl_en) begin
					next_state = adsd_pkg::adsd_conv_req;
				end
			end
			adsd_pkg::adsd_conv_req: begin
				next_state = adsd_pkg::adsd_conv_wait;
			end
			adsd_pkg::adsd_conv_wait: begin
				if (conv_done) begin
					next_state = adsd_pkg::adsd_xfer;
				end
			end
			adsd_pkg::adsd_xfer: begin
				if (wr_done) begin
					next_state = adsd_pkg::adsd_conv_req;
				end
			end
			default: begin
				next_state = adsd_pkg::adsd_idle;
			end
		endcase
		if (!ctrl_en) begin
			next_state = adsd_pkg::adsd_idle;
		end
	end

	// input number advances only after its result is stored, and clears to zero while disabled or idle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state <= adsd_pkg::adsd_idle;
			cur <= STAT_RST[`ADSD_CUR_MSB:`ADSD_CUR_LSB];
			wr_start <= 1'b0;
			result_q <= 10'h000;
		end else begin
			state <= next_state;
			wr_start <= 1'b0;
			if (!ctrl_en || state == adsd_pkg::adsd_idle) begin
				cur <= 4'h0;
			end else if (state == adsd_pkg::adsd_xfer && wr_done) begin
				cur <= at_last ? 4'h0 : cur + 4'h1;
			end
			if (state == adsd_pkg::adsd_conv_wait && conv_done && ctrl_en) begin
				result_q <= conv_result;
				wr_start <= 1'b1;
			end
		end
	end

	// request is a one-cycle strobe with no handshake, the input number comes from the register
	assign conv_start = (state == adsd_pkg::adsd_conv_req);
	assign conv_input = cur;

	// ********************************
	// result transfer
	// ********************************
	// writer held clear while the channel is disabled
	adsd_result_writer u_writer (
		.aclk(aclk),
		.aresetn(aresetn),
		.start(wr_start),
		.abort(!ctrl_en),
		.base_upper(result_base_upper_bits),
		.input_number(cur),
		.result(result_q),
		.rf_wr_valid(rf_wr_valid),
		.rf_wr_ready(rf_wr_ready),
		.rf_wr_addr(rf_wr_addr),
		.rf_wr_data(rf_wr_data),
		.done(wr_done)
	);

	// ********************************
	// indicators and interrupt
	// ********************************
	// a set in the same cycle as the clearing read wins, so no event is lost
	wire stat_read = rd_take && rd_stat;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flag_scan <= STAT_RST[`ADSD_FLAG_SCAN];
			flag_ch1 <= STAT_RST[`ADSD_FLAG_CH1];
			flag_ch0 <= STAT_RST[`ADSD_FLAG_CH0];
			scan_irq <= 1'b0;
		end else begin
			flag_scan <= raise_irq || (flag_scan && !stat_read);
			flag_ch1 <= chan1_done || (flag_ch1 && !stat_read);
			flag_ch0 <= chan0_done || (flag_ch0 && !stat_read);
			scan_irq <= raise_irq;
		end
	end
endmodule

// *** verif/adsd_scan_dma_assertions.sv ***
`timescale 1ns/100ps

// ****************
// protocol checker
// ****************
module adsd_scan_dma_chk (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, active low
	input wire logic s_axi_arvalid, // read address valid
	input wire logic s_axi_arready, // read address ready
	input wire logic s_axi_rvalid, // read data valid
	input wire logic conv_start, // conversion request
	input wire logic [3:0] conv_input, // input converted
	input wire logic conv_done, // end of conversion
	input wire logic rf_wr_valid, // byte offered
	input wire logic rf_wr_ready, // byte taken
	input wire logic [11:0] rf_wr_addr, // byte address
	input wire logic [6:0] result_base_upper_bits, // base bits
	input wire logic scan_irq // scan interrupt
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// request and interrupt are single pulses
	chk_start_pulse: assert property (conv_start |=> !conv_start) else $error("start too long");
	chk_irq_pulse: assert property (scan_irq |=> !scan_irq) else $error("irq too long");
	// transfer only after a finished conversion
	chk_xfer_after: assert property ($rose(rf_wr_valid) |-> $past(conv_done, 2)) else $error("early write");
	chk_even_addr: assert property ($rose(rf_wr_valid) |->
		rf_wr_addr == {result_base_upper_bits, conv_input, 1'b0}) else $error("bad even address");
	chk_odd_next: assert property (rf_wr_valid && rf_wr_ready && !rf_wr_addr[0] |=>
		rf_wr_valid && rf_wr_addr[0]) else $error("odd byte missing");
	chk_irq_store: assert property (scan_irq |->
		$past(rf_wr_valid && rf_wr_ready && rf_wr_addr[0], 2)) else $error("irq without store");
	chk_next_input: assert property ($fell(rf_wr_valid) |=> conv_start) else $error("no next start");
	chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
endmodule

bind adsd_scan_dma adsd_scan_dma_chk i_chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
	.conv_start, .conv_input, .conv_done, .rf_wr_valid, .rf_wr_ready, .rf_wr_addr, .result_base_upper_bits, .scan_irq);

// *** verif/adsd_partner.sv ***
`timescale 1ns/100ps

// ****************
// converter and register file model
// ****************
module adsd_partner (
	input wire logic aclk, // clock
	input wire logic aresetn, // reset, active low
	input wire logic hold, // freeze the conversion
	input wire logic conv_start, // conversion request
	output logic conv_done, // end pulse
	output logic [9:0] conv_result, // result
	output logic rf_wr_ready // byte accept, random stalls
);
	logic [31:0] rnd;
	logic [3:0] cnt;
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	// result lines change every cycle so a late sample shows up wrong
	always @(posedge aclk) begin
		rnd <= aresetn ? lfsr(rnd) : 32'ha785;
		conv_result <= rnd[9:0];
		rf_wr_ready <= rnd[11] | rnd[12];
		conv_done <= aresetn && !hold && cnt == 4'h1;
		if (!aresetn)
			cnt <= 4'h0;
		else if (conv_start)
			cnt <= {1'b0, rnd[15:13]} + 4'h2;
		else if (cnt != 4'h0 && !hold)
			cnt <= cnt - 4'h1;
	end
endmodule

// *** verif/test_adsd_scan_dma.sv ***
`timescale 1ns/100ps
`include "adsd_defs.svh"
`define CHK(n, e, a) begin compares++; if ((a) !== (e)) begin error_cnt++; \
	$display("CHECK FAILED %s exp %h got %h", n, e, a); end end

module test_adsd_scan_dma;
	localparam logic [15:0] CTRL = 16'(`ADSD_CTRL_IDX * 4);
	localparam logic [15:0] STAT = 16'(`ADSD_STAT_IDX * 4);
	logic aclk = 0, aresetn = 0, hold = 0, act = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_arvalid = 0, s_axi_bready = 1, s_axi_rready = 1;
	logic chan0_done = 0, chan1_done = 0;
	logic [15:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
	logic [3:0] s_axi_wstrb = 4'hf, exp_in = 0, last = 0;
	logic [31:0] s_axi_wdata = 0, rnd = 32'ha785;
	logic [6:0] result_base_upper_bits = 0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic conv_start, conv_done, rf_wr_valid, rf_wr_ready, scan_irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [3:0] conv_input;
	logic [9:0] conv_result;
	logic [11:0] rf_wr_addr;
	logic [7:0] rf_wr_data;
	logic [1:0] bq[$];
	logic [33:0] rq[$];
	logic [19:0] wq[$];
	logic [33:0] re;
	logic [1:0] be;
	logic [19:0] we;
	int error_cnt = 0, compares = 0, irqs = 0, scans = 0;

	adsd_scan_dma i_dut (.*);
	adsd_partner i_far (.*);

	always #2.5 aclk = ~aclk;

	// ****************
	// result watcher
	// ****************
	always @(posedge aclk) if (aresetn) begin
		if (s_axi_bvalid) begin
			be = bq.pop_front();
			`CHK("bresp", be, s_axi_bresp)
		end
		if (s_axi_rvalid) begin
			re = rq.pop_front();
			`CHK("rresp", re[33:32], s_axi_rresp)
			`CHK("rdata", re[31:0], s_axi_rdata)
		end
		if (conv_start && act) `CHK("conv_input", exp_in, conv_input)
		if (conv_done && act) begin
			wq.push_back({result_base_upper_bits, exp_in, 1'b0, conv_result[9:2]});
			wq.push_back({result_base_upper_bits, exp_in, 1'b1, conv_result[1:0], 6'h00});
			exp_in = (exp_in == last) ? 4'h0 : exp_in + 4'h1;
		end
		if (rf_wr_valid && rf_wr_ready) begin
			we = wq.pop_front();
			`CHK("rf_write", we, {rf_wr_addr, rf_wr_data})
			if (we[8] && we[12:9] == last) scans++;
		end
		if (scan_irq) irqs++;
	end

	// ****************
	// bus tasks and scenarios
	// ****************
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] r);
		bq.push_back(r);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h0, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
		end while (s_axi_awvalid || s_axi_wvalid);
		while (!s_axi_bvalid) @(posedge aclk);
	endtask

	task automatic rd(input logic [15:0] a, input logic [31:0] d, input logic [1:0] r);
		rq.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 0;
		do @(posedge aclk); while (!s_axi_rvalid);
	endtask

	// two full scans, then freeze the converter and inspect the status
	task automatic run(input logic [3:0] n, input logic ie, input logic [1:0] chf);
		rnd = lfsr(rnd);
		result_base_upper_bits <= rnd[6:0];
		exp_in = 0;
		last = n;
		act = 1;
		irqs = 0;
		scans = 0;
		wr(CTRL, {1'b1, ie, 2'b00, n}, `ADSD_RESP_OKAY);
		repeat (3000) if (scans < 2) @(posedge aclk);
		`CHK("scan_count", 1'b1, scans >= 2)
		hold <= 1;
		chan0_done <= chf[0];
		chan1_done <= chf[1];
		@(posedge aclk);
		chan0_done <= 0;
		chan1_done <= 0;
		repeat (30) @(posedge aclk);
		`CHK("irq_count", ie ? 2 : 0, irqs)
		rd(STAT, {24'h0, exp_in, 1'b0, ie, chf}, `ADSD_RESP_OKAY);
		act = 0;
		wr(CTRL, {1'b0, ie, 2'b00, n}, `ADSD_RESP_OKAY);
		rd(CTRL, {24'h0, 1'b0, ie, 6'h00}, `ADSD_RESP_OKAY);
		rd(STAT, 32'h0, `ADSD_RESP_OKAY);
		hold <= 0;
		repeat (20) @(posedge aclk);
		$display("scan test last %0d done", n);
	endtask

	task print_verdict;
		$display("compares %0d mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1;
		@(posedge aclk);
		rd(CTRL, 32'h0, `ADSD_RESP_OKAY);
		rd(STAT, 32'h0, `ADSD_RESP_OKAY);
		rd(16'h0010, 32'h0, `ADSD_RESP_SLVERR);
		wr(16'h0010, 8'hff, `ADSD_RESP_SLVERR);
		wr(STAT, 8'hf7, `ADSD_RESP_OKAY);
		rd(STAT, 32'h0, `ADSD_RESP_OKAY);
		s_axi_wstrb <= 4'h0;
		wr(CTRL, 8'h85, `ADSD_RESP_OKAY);
		rd(CTRL, 32'h0, `ADSD_RESP_OKAY);
		s_axi_wstrb <= 4'hf;
		$display("register test done");
		run(4'h0, 1, 2'b01);
		run(4'h5, 0, 2'b10);
		run(4'hb, 1, 2'b11);
		print_verdict;
	end

	// hang guard, far beyond the few hundred cycles the scans need
	initial begin
		#100000;
		error_cnt++;
		print_verdict;
	end
endmodule
